// ### src/ifr_pkg.sv
package ifr_pkg;
  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] A_FORMAT = 8'h00;
  localparam logic [7:0] A_WIDTH = 8'h04;
  localparam logic [7:0] A_HEIGHT = 8'h08;
  localparam logic [7:0] A_COL = 8'h0C;
  localparam logic [7:0] A_ROW = 8'h10;
  localparam logic [7:0] A_MIRROR = 8'h14;
  localparam logic [7:0] A_LAYOUT = 8'h18;
  localparam logic [7:0] A_KIND = 8'h1C;
  localparam logic [7:0] A_DEPTH = 8'h20;
  localparam logic [7:0] A_ORDER = 8'h24;
  localparam logic [7:0] A_PATTERN = 8'h28;
  localparam logic [7:0] A_STREAM = 8'h2C;
  localparam logic [7:0] A_NOTIFY = 8'h30;
  localparam logic [7:0] A_TRIAL = 8'h34;
  localparam logic [7:0] A_RESTART = 8'h38;
  localparam logic [7:0] A_STATUS = 8'h3C;
  localparam logic [7:0] A_REJECT = 8'h40;
  localparam logic [7:0] A_IDENT = 8'h80;
  localparam logic [7:0] A_LABEL = 8'hC0;
  localparam int LABEL_WORDS = 16;
  localparam int IDENT_WORDS = 5;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam logic [11:0] COL_STEP = 12'h008;
  localparam logic [11:0] ROW_STEP = 12'h002;
  localparam logic [11:0] MIN_W = 12'h040;
  localparam logic [11:0] MIN_H = 12'h040;
  localparam logic [11:0] FULL_W = 12'hFA0;
  localparam logic [11:0] FULL_H = 12'hBB8;
  // ************************************************************
  // Codes and fills
  // ************************************************************
  localparam logic [31:0] CODE_GREY8 = 32'h0108_0001;
  localparam logic [31:0] CODE_MOSAIC8 = 32'h0108_000B;
  localparam logic [7:0] FILL_WHITE = 8'hFF;
  localparam logic [7:0] FILL_LIGHT = 8'hAA;
  localparam logic [7:0] FILL_DARK = 8'h55;
  localparam logic [7:0] FILL_BLACK = 8'h00;
  localparam logic [11:0] BAR_W = 12'h1F4;
  localparam logic [1:0] FMT_COUNT = 2'h3;
  localparam int RESTART_CYCLES = 16;

  typedef enum logic [1:0] {
    first_layout, second_layout, third_layout
  } ifr_format_t;
  typedef enum logic [0:0] {grey_kind, mosaic_kind} ifr_kind_t;
  typedef enum logic [2:0] {
    pat_off, pat_black, pat_white, light_grey_fill, dark_grey_fill,
    column_ramp, row_ramp, colour_stripes
  } ifr_pattern_t;
  // Scan position state
  typedef enum {st_idle, st_line} ifr_scan_t;
endpackage

// ### src/ifr_top.sv
`timescale 1ns/1ps
module ifr_top #(
  parameter logic [31:0] VENDOR_WORD = 32'h0000_1111, // arbitrary
  parameter logic [31:0] MODEL_WORD = 32'h0000_2222, // arbitrary
  parameter logic [31:0] MAKER_WORD = 32'h0000_3333, // arbitrary
  parameter logic [31:0] VERSION_WORD = 32'h0000_0001, // arbitrary
  parameter logic [31:0] SERIAL_WORD = 32'h0000_4444 // arbitrary
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic streaming,
  input wire logic pix_valid,
  input wire logic [7:0] pix_data,
  input wire logic pix_sol,
  input wire logic pix_sof,
  output logic [7:0] out_data,
  output logic out_valid,
  output logic [11:0] out_col,
  output logic [11:0] out_row,
  output logic trial_notice,
  output logic restart_req
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [1:0] format_choice;
    logic [11:0] width;
    logic [11:0] height;
    logic [11:0] roi_start_col;
    logic [11:0] roi_start_row;
    logic mirror_horizontal;
    logic mirror_vertical;
    logic pixel_colour_kind;
    logic pixel_bit_depth;
    logic pixel_byte_order;
    logic [2:0] synthetic_image_select;
    logic stream_channel_open;
    logic notify_on;
    logic trial;
    logic [4:0] restart_cnt;
    logic rejected;
    logic [11:0] col;
    logic [11:0] row;
    logic [7:0] data;
    logic valid;
    logic [31:0] rdata;
    logic ack;
  } ifr_state_t;

  ifr_state_t s_q, s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [31:0] label_q [ifr_pkg::LABEL_WORDS];
  logic acc, wr, rd;
  logic [31:0] wmask, wval;
  logic [11:0] wv;
  logic [31:0] layout_code;
  logic lab_hit;
  logic [3:0] lab_idx;
  logic [11:0] end_col, end_row, hc, vr, pc, pr;
  logic [7:0] ramp_c, ramp_r, pat_px;
  logic [2:0] bar;

  // ************************************************************
  // Reset release
  // ************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign acc = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = acc && wb_we_i;
  assign rd = acc && !wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wval = wb_dat_i & wmask;
  assign wv = wval[11:0];
  assign lab_hit = wb_adr_i[7:6] == ifr_pkg::A_LABEL[7:6];
  assign lab_idx = wb_adr_i[5:2];

  always_comb begin
    if (s_q.pixel_colour_kind == ifr_pkg::mosaic_kind) begin
      layout_code = ifr_pkg::CODE_MOSAIC8;
    end else begin
      layout_code = ifr_pkg::CODE_GREY8;
    end
  end

  assign end_col = 12'(s_q.roi_start_col + s_q.width);
  assign end_row = 12'(s_q.roi_start_row + s_q.height);

  // ************************************************************
  // Test pattern generator
  // ************************************************************
  // window position only tags pixels, it never paces the stream
  always_comb begin
    // Pattern follows the pixel now arriving, not the last one
    if (pix_sof) begin
      pc = 12'h000;
      pr = 12'h000;
    end else if (pix_sol) begin
      pc = 12'h000;
      pr = 12'(s_q.row + 12'h001);
    end else begin
      pc = 12'(s_q.col + 12'h001);
      pr = s_q.row;
    end
    hc = s_q.mirror_horizontal ? 12'(end_col - 12'h001 - pc)
                               : 12'(s_q.roi_start_col + pc);
    vr = s_q.mirror_vertical ? 12'(end_row - 12'h001 - pr)
                             : 12'(s_q.roi_start_row + pr);
    ramp_c = hc[11:4];
    ramp_r = vr[11:4];
    bar = 3'(hc / ifr_pkg::BAR_W);
    case (ifr_pkg::ifr_pattern_t'(s_q.synthetic_image_select))
      ifr_pkg::pat_off: pat_px = pix_data;
      ifr_pkg::pat_black: pat_px = ifr_pkg::FILL_BLACK;
      ifr_pkg::pat_white: pat_px = ifr_pkg::FILL_WHITE;
      ifr_pkg::light_grey_fill: pat_px = ifr_pkg::FILL_LIGHT;
      ifr_pkg::dark_grey_fill: pat_px = ifr_pkg::FILL_DARK;
      ifr_pkg::column_ramp: pat_px = ramp_c;
      ifr_pkg::row_ramp: pat_px = ramp_r;
      ifr_pkg::colour_stripes: pat_px = {bar, 5'h00};
      default: pat_px = pix_data;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.trial = 1'b0;
    s_d.ack = acc;
    s_d.valid = 1'b0;
    if (s_q.restart_cnt != 5'h00) begin
      s_d.restart_cnt = 5'(s_q.restart_cnt - 5'h01);
    end
    // Pixel walk over the single rectangle
    if (pix_valid) begin
      s_d.col = pc;
      s_d.row = pr;
      s_d.data = pat_px;
      s_d.valid = s_q.stream_channel_open;
    end
    s_d.rdata = 32'h0000_0000;
    if (rd) begin
      case (wb_adr_i)
        ifr_pkg::A_FORMAT: s_d.rdata = 32'(s_q.format_choice);
        ifr_pkg::A_WIDTH: s_d.rdata = 32'(s_q.width);
        ifr_pkg::A_HEIGHT: s_d.rdata = 32'(s_q.height);
        ifr_pkg::A_COL: s_d.rdata = 32'(s_q.roi_start_col);
        ifr_pkg::A_ROW: s_d.rdata = 32'(s_q.roi_start_row);
        ifr_pkg::A_MIRROR:
          s_d.rdata = 32'({s_q.mirror_vertical, s_q.mirror_horizontal});
        ifr_pkg::A_LAYOUT: s_d.rdata = layout_code;
        ifr_pkg::A_KIND: s_d.rdata = 32'(s_q.pixel_colour_kind);
        ifr_pkg::A_DEPTH: s_d.rdata = 32'(s_q.pixel_bit_depth);
        ifr_pkg::A_ORDER: s_d.rdata = 32'(s_q.pixel_byte_order);
        ifr_pkg::A_PATTERN: s_d.rdata = 32'(s_q.synthetic_image_select);
        ifr_pkg::A_STREAM: s_d.rdata = 32'(s_q.stream_channel_open);
        ifr_pkg::A_NOTIFY: s_d.rdata = 32'(s_q.notify_on);
        ifr_pkg::A_STATUS: s_d.rdata = 32'(streaming);
        ifr_pkg::A_REJECT: s_d.rdata = 32'(s_q.rejected);
        ifr_pkg::A_IDENT: s_d.rdata = VENDOR_WORD;
        8'h84: s_d.rdata = MODEL_WORD;
        8'h88: s_d.rdata = MAKER_WORD;
        8'h8C: s_d.rdata = VERSION_WORD;
        8'h90: s_d.rdata = SERIAL_WORD;
        default: s_d.rdata = lab_hit ? label_q[lab_idx] : 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        ifr_pkg::A_FORMAT: begin
          if (!streaming && wv[1:0] < ifr_pkg::FMT_COUNT) begin
            s_d.format_choice = wv[1:0];
          end
        end
        ifr_pkg::A_WIDTH: begin
          // Misfit values are dropped, not clamped, and flagged
          if (!streaming) begin
            if (wv >= ifr_pkg::MIN_W && wv[2:0] == 3'h0 &&
                13'(wv) + 13'(s_q.roi_start_col) <=
                13'(ifr_pkg::FULL_W)) begin
              s_d.width = wv;
              s_d.rejected = 1'b0;
            end else begin
              s_d.rejected = 1'b1;
            end
          end
        end
        ifr_pkg::A_HEIGHT: begin
          if (!streaming) begin
            if (wv >= ifr_pkg::MIN_H && wv[0] == 1'b0 &&
                13'(wv) + 13'(s_q.roi_start_row) <=
                13'(ifr_pkg::FULL_H)) begin
              s_d.height = wv;
              s_d.rejected = 1'b0;
            end else begin
              s_d.rejected = 1'b1;
            end
          end
        end
        ifr_pkg::A_COL: begin
          if (!streaming) begin
            if (wv[2:0] == 3'h0 && 13'(wv) + 13'(s_q.width) <=
                13'(ifr_pkg::FULL_W)) begin
              s_d.roi_start_col = wv;
              s_d.rejected = 1'b0;
            end else begin
              s_d.rejected = 1'b1;
            end
          end
        end
        ifr_pkg::A_ROW: begin
          if (!streaming) begin
            if (wv[0] == 1'b0 && 13'(wv) + 13'(s_q.height) <=
                13'(ifr_pkg::FULL_H)) begin
              s_d.roi_start_row = wv;
              s_d.rejected = 1'b0;
            end else begin
              s_d.rejected = 1'b1;
            end
          end
        end
        ifr_pkg::A_MIRROR: begin
          s_d.mirror_horizontal = wval[0];
          s_d.mirror_vertical = wval[1];
        end
        ifr_pkg::A_KIND: s_d.pixel_colour_kind = wval[0];
        ifr_pkg::A_DEPTH: begin
          if (!streaming) begin
            s_d.pixel_bit_depth = wval[0];
          end
        end
        ifr_pkg::A_ORDER: s_d.pixel_byte_order = wval[0];
        ifr_pkg::A_PATTERN: s_d.synthetic_image_select = wval[2:0];
        ifr_pkg::A_STREAM: s_d.stream_channel_open = wval[0];
        ifr_pkg::A_NOTIFY: s_d.notify_on = wval[0];
        ifr_pkg::A_TRIAL: s_d.trial = wval[0] && s_q.notify_on;
        ifr_pkg::A_RESTART: begin
          if (wval[0]) begin
            s_d.restart_cnt = 5'(ifr_pkg::RESTART_CYCLES);
          end
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.width <= ifr_pkg::FULL_W;
      s_q.height <= ifr_pkg::FULL_H;
      s_q.pixel_colour_kind <= ifr_pkg::mosaic_kind;
    end else begin
      s_q <= s_d;
    end
  end

  // Label lives in plain flops; persistence is the outer store's job
  always_ff @(posedge clock) begin
    if (wr && lab_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          label_q[lab_idx][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign out_data = s_q.data;
  assign out_valid = s_q.valid;
  assign out_col = s_q.col;
  assign out_row = s_q.row;
  assign trial_notice = s_q.trial;
  assign restart_req = s_q.restart_cnt != 5'h00;

  // ************************************************************
  // Checks
  // ************************************************************
  a_format_locked: assert property (@(posedge clock) disable iff (!rst_n)
    streaming && wr && wb_adr_i == ifr_pkg::A_FORMAT |=>
      $stable(s_q.format_choice))
    else $error("format changed while streaming");
  a_roi_locked: assert property (@(posedge clock) disable iff (!rst_n)
    streaming && wr && wb_adr_i == ifr_pkg::A_WIDTH |=> $stable(s_q.width))
    else $error("width changed while streaming");
  a_width_grid: assert property (@(posedge clock) disable iff (!rst_n)
    s_q.width[2:0] == 3'h0 && s_q.width >= ifr_pkg::MIN_W)
    else $error("width off grid");
  a_start_grid: assert property (@(posedge clock) disable iff (!rst_n)
    s_q.roi_start_col[2:0] == 3'h0 && s_q.roi_start_row[0] == 1'b0)
    else $error("start off grid");
  a_roi_fits: assert property (@(posedge clock) disable iff (!rst_n)
    13'(s_q.roi_start_row) + 13'(s_q.height) <= 13'(ifr_pkg::FULL_H))
    else $error("region exceeds image");
  a_code_map: assert property (@(posedge clock) disable iff (!rst_n)
    rd && wb_adr_i == ifr_pkg::A_LAYOUT && !s_q.pixel_colour_kind |=>
      wb_dat_o == ifr_pkg::CODE_GREY8)
    else $error("wrong layout code");
  a_white_fill: assert property (@(posedge clock) disable iff (!rst_n)
    pix_valid && s_q.synthetic_image_select == 3'h2 |=>
      out_data == ifr_pkg::FILL_WHITE)
    else $error("white fill wrong");
  a_trial_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    trial_notice |=> !trial_notice)
    else $error("trial notice too long");
  a_stream_gate: assert property (@(posedge clock) disable iff (!rst_n)
    out_valid |-> $past(s_q.stream_channel_open))
    else $error("pixel out with channel closed");
  a_depth_locked: assert property (@(posedge clock) disable iff (!rst_n)
    streaming && wr && wb_adr_i == ifr_pkg::A_DEPTH |=>
      $stable(s_q.pixel_bit_depth))
    else $error("bit depth changed while streaming");
  a_height_grid: assert property (@(posedge clock) disable iff (!rst_n)
    s_q.height[0] == 1'b0 && s_q.height >= ifr_pkg::MIN_H)
    else $error("height off grid");
  a_col_fits: assert property (@(posedge clock) disable iff (!rst_n)
    13'(s_q.roi_start_col) + 13'(s_q.width) <= 13'(ifr_pkg::FULL_W))
    else $error("region exceeds image width");
  a_col_locked: assert property (@(posedge clock) disable iff (!rst_n)
    streaming && wr && wb_adr_i == ifr_pkg::A_COL |=>
      $stable(s_q.roi_start_col))
    else $error("start column changed while streaming");
  a_row_locked: assert property (@(posedge clock) disable iff (!rst_n)
    streaming && wr && wb_adr_i == ifr_pkg::A_ROW |=>
      $stable(s_q.roi_start_row))
    else $error("start row changed while streaming");
  a_height_locked: assert property (@(posedge clock) disable iff (!rst_n)
    streaming && wr && wb_adr_i == ifr_pkg::A_HEIGHT |=>
      $stable(s_q.height))
    else $error("height changed while streaming");
  a_black_fill: assert property (@(posedge clock) disable iff (!rst_n)
    pix_valid && s_q.synthetic_image_select == 3'h1 |=>
      out_data == ifr_pkg::FILL_BLACK)
    else $error("black fill wrong");
  a_light_fill: assert property (@(posedge clock) disable iff (!rst_n)
    pix_valid && s_q.synthetic_image_select == 3'h3 |=>
      out_data == ifr_pkg::FILL_LIGHT)
    else $error("light grey fill wrong");
  a_dark_fill: assert property (@(posedge clock) disable iff (!rst_n)
    pix_valid && s_q.synthetic_image_select == 3'h4 |=>
      out_data == ifr_pkg::FILL_DARK)
    else $error("dark grey fill wrong");
  a_sensor_pass: assert property (@(posedge clock) disable iff (!rst_n)
    pix_valid && s_q.synthetic_image_select == 3'h0 |=>
      out_data == $past(pix_data))
    else $error("sensor data not passed");
  a_mosaic_code: assert property (@(posedge clock) disable iff (!rst_n)
    rd && wb_adr_i == ifr_pkg::A_LAYOUT && s_q.pixel_colour_kind |=>
      wb_dat_o == ifr_pkg::CODE_MOSAIC8)
    else $error("wrong mosaic layout code");
  a_trial_gated: assert property (@(posedge clock) disable iff (!rst_n)
    trial_notice |-> $past(s_q.notify_on))
    else $error("trial notice with notify off");
  a_format_range: assert property (@(posedge clock) disable iff (!rst_n)
    s_q.format_choice < ifr_pkg::FMT_COUNT)
    else $error("format out of range");
endmodule

// ### bench/ifr_sensor_model.sv
`timescale 1ns/1ps
module ifr_sensor_model (
  input wire logic clock,
  input wire logic fire,
  input wire logic [7:0] level,
  output logic pix_valid,
  output logic [7:0] pix_data,
  output logic pix_sol,
  output logic pix_sof
);
  initial begin
    pix_valid = 0;
    pix_data = 8'h00;
    pix_sol = 0;
    pix_sof = 0;
  end
  // Idle data toggles so a stale pixel never looks fresh
  always @(posedge clock) begin
    pix_valid <= fire;
    pix_sol <= fire;
    pix_sof <= fire;
    pix_data <= fire ? level : ~pix_data;
  end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock = 0;
  logic resetn = 0;
  logic cyc = 0, stb = 0, we = 0, streaming = 0, fire = 0;
  logic [7:0] adr = 8'h00, level = 8'h00, pix_data, out_data;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o, v;
  logic ack, pix_valid, pix_sol, pix_sof, out_valid;
  logic trial_notice, restart_req;
  logic [11:0] out_col, out_row;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  int n_notice = 0, n_restart = 0, n0;
  logic [7:0] fills [8];
  logic [31:0] idents [5];
  always #2 clock = ~clock;
  ifr_top ifr_top_inst (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .streaming(streaming), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_sol(pix_sol), .pix_sof(pix_sof), .out_data(out_data),
    .out_valid(out_valid), .out_col(out_col), .out_row(out_row),
    .trial_notice(trial_notice), .restart_req(restart_req));
  ifr_sensor_model ifr_sensor_model_inst (.clock(clock), .fire(fire),
    .level(level), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_sol(pix_sol), .pix_sof(pix_sof));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task conclude;
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits for ack with no cycle count assumed; the watchdog cuts hangs
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clock); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask
  task pix(input logic [7:0] lv, input logic [7:0] e, input logic ok);
    @(posedge clock);
    fire <= 1;
    level <= lv;
    @(posedge clock);
    fire <= 0;
    repeat (2) @(posedge clock);
    chk(32'(out_valid), 32'(ok));
    if (ok) begin
      chk(32'(out_data), 32'(e));
      chk(32'({out_col, out_row}), 32'h0000_0000);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (trial_notice === 1'b1) n_notice++;
    if (restart_req === 1'b1) n_restart++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude;
    end
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_defaults;
    rd(ifr_pkg::A_FORMAT, 32'h0000_0000);
    rd(ifr_pkg::A_WIDTH, 32'(ifr_pkg::FULL_W));
    rd(ifr_pkg::A_HEIGHT, 32'(ifr_pkg::FULL_H));
    rd(ifr_pkg::A_MIRROR, 32'h0000_0000);
    rd(ifr_pkg::A_LAYOUT, ifr_pkg::CODE_MOSAIC8);
    rd(ifr_pkg::A_PATTERN, 32'h0000_0000);
    rd(ifr_pkg::A_STREAM, 32'h0000_0000);
    rd(ifr_pkg::A_REJECT, 32'h0000_0000);
    $display("defaults done");
  endtask
  task t_codes;
    wr(ifr_pkg::A_KIND, 32'h0000_0000);
    rd(ifr_pkg::A_LAYOUT, ifr_pkg::CODE_GREY8);
    wr(ifr_pkg::A_KIND, 32'h0000_0001);
    rd(ifr_pkg::A_LAYOUT, ifr_pkg::CODE_MOSAIC8);
    wr(ifr_pkg::A_ORDER, 32'h0000_0001);
    rd(ifr_pkg::A_ORDER, 32'h0000_0001);
    for (int i = 1; i < 4; i++) begin
      wr(ifr_pkg::A_FORMAT, 32'(i));
      rd(ifr_pkg::A_FORMAT, 32'(i < 3 ? i : 2));
    end
    for (int m = 0; m < 4; m++) begin
      wr(ifr_pkg::A_MIRROR, 32'(m));
      rd(ifr_pkg::A_MIRROR, 32'(m));
    end
    wr(ifr_pkg::A_FORMAT, 32'h0000_0000);
    $display("codes done");
  endtask
  task t_roi;
    wr(ifr_pkg::A_WIDTH, 32'h0000_0048);
    wr(ifr_pkg::A_WIDTH, 32'h0000_0044);
    rd(ifr_pkg::A_WIDTH, 32'h0000_0048);
    rd(ifr_pkg::A_REJECT, 32'h0000_0001);
    wr(ifr_pkg::A_HEIGHT, 32'h0000_0042);
    wr(ifr_pkg::A_HEIGHT, 32'h0000_003E);
    rd(ifr_pkg::A_HEIGHT, 32'h0000_0042);
    wr(ifr_pkg::A_COL, 32'h0000_0004);
    wr(ifr_pkg::A_COL, 32'h0000_0008);
    rd(ifr_pkg::A_COL, 32'h0000_0008);
    wr(ifr_pkg::A_ROW, 32'h0000_0003);
    wr(ifr_pkg::A_ROW, 32'h0000_0002);
    rd(ifr_pkg::A_ROW, 32'h0000_0002);
    wr(ifr_pkg::A_WIDTH, 32'(ifr_pkg::FULL_W));
    rd(ifr_pkg::A_WIDTH, 32'h0000_0048);
    $display("roi done");
  endtask
  task t_lock;
    @(posedge clock);
    streaming <= 1;
    rd(ifr_pkg::A_STATUS, 32'h0000_0001);
    wr(ifr_pkg::A_FORMAT, 32'h0000_0001);
    rd(ifr_pkg::A_FORMAT, 32'h0000_0000);
    wr(ifr_pkg::A_WIDTH, 32'h0000_0050);
    rd(ifr_pkg::A_WIDTH, 32'h0000_0048);
    wr(ifr_pkg::A_ROW, 32'h0000_0004);
    rd(ifr_pkg::A_ROW, 32'h0000_0002);
    bus(0, ifr_pkg::A_DEPTH, 32'h0000_0000);
    v = rdat;
    wr(ifr_pkg::A_DEPTH, ~v);
    rd(ifr_pkg::A_DEPTH, v);
    @(posedge clock);
    streaming <= 0;
    $display("lock done");
  endtask
  task t_pixel;
    wr(ifr_pkg::A_COL, 32'h0000_0000);
    wr(ifr_pkg::A_ROW, 32'h0000_0000);
    pix(8'h3C, 8'h00, 0);
    wr(ifr_pkg::A_STREAM, 32'h0000_0001);
    // Mirrors stay on from t_codes: ramps see the far corner 0x47, 0x41
    fills = '{8'h3C, ifr_pkg::FILL_BLACK, ifr_pkg::FILL_WHITE,
      ifr_pkg::FILL_LIGHT, ifr_pkg::FILL_DARK, 8'h04, 8'h04, 8'h00};
    for (int p = 0; p < 8; p++) begin
      wr(ifr_pkg::A_PATTERN, 32'(p));
      pix(8'h3C, fills[p], 1);
    end
    for (int p = 5; p < 8; p++) begin
      wr(ifr_pkg::A_PATTERN, 32'(p));
      rd(ifr_pkg::A_PATTERN, 32'(p));
    end
    wr(ifr_pkg::A_PATTERN, 32'h0000_0000);
    wr(ifr_pkg::A_STREAM, 32'h0000_0000);
    pix(8'hC3, 8'h00, 0);
    $display("pixel done");
  endtask
  task t_events;
    n0 = n_notice;
    wr(ifr_pkg::A_TRIAL, 32'h0000_0001);
    repeat (4) @(posedge clock);
    chk(32'(n_notice), 32'(n0));
    wr(ifr_pkg::A_NOTIFY, 32'h0000_0001);
    wr(ifr_pkg::A_TRIAL, 32'h0000_0001);
    repeat (4) @(posedge clock);
    chk(32'(n_notice), 32'(n0 + 1));
    for (int i = 0; i < ifr_pkg::LABEL_WORDS; i++)
      wr(ifr_pkg::A_LABEL + 8'(4 * i), 32'hA5A5_0000 + 32'(i));
    for (int i = 0; i < ifr_pkg::LABEL_WORDS; i++)
      rd(ifr_pkg::A_LABEL + 8'(4 * i), 32'hA5A5_0000 + 32'(i));
    idents = '{32'h0000_1111, 32'h0000_2222, 32'h0000_3333,
      32'h0000_0001, 32'h0000_4444};
    wr(ifr_pkg::A_IDENT, 32'hFFFF_FFFF);
    for (int i = 0; i < ifr_pkg::IDENT_WORDS; i++)
      rd(ifr_pkg::A_IDENT + 8'(4 * i), idents[i]);
    rd(8'h44, 32'h0000_0000);
    n0 = n_restart;
    wr(ifr_pkg::A_RESTART, 32'h0000_0001);
    repeat (30) @(posedge clock);
    chk(32'(n_restart - n0), 32'(ifr_pkg::RESTART_CYCLES));
    $display("events done");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1;
    repeat (3) @(posedge clock);
    t_defaults;
    t_codes;
    t_roi;
    t_lock;
    t_pixel;
    t_events;
    conclude;
  end
endmodule
